// File: cmi_core.sv
// Executes the misc single-word instruction group of a 4-bit controller core
`timescale 1ns/1ps
`default_nettype none

module cmi_core
  import cmi_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire cmi_instr_t i_instr,
  input wire logic [CMI_NIB_W-1:0] i_mem_rdata,
  input wire logic [CMI_Y_W-1:0] i_reg_y,
  input wire logic i_large_rom,
  input wire logic i_call_valid,
  input wire logic [CMI_PC_W-1:0] i_call_addr,
  input wire logic [CMI_NIB_W-1:0] i_acc_load,
  input wire logic i_acc_load_valid,
  input wire logic i_bank_set,
  output logic o_ready,
  output logic [CMI_NIB_W-1:0] o_acc,
  output logic o_carry_flag,
  output logic o_bank_flag,
  output logic o_backup,
  output logic [CMI_PORTD_W-1:0] o_port_d,
  output logic [CMI_PC_W-1:0] o_program_counter,
  output logic [CMI_SP_W-1:0] o_stack_pointer,
  output cmi_mem_wr_t o_mem_wr
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic is_op(input logic [CMI_INSTR_W-1:0] code, input logic [CMI_INSTR_W-1:0] op);
    is_op = (code == op);
  endfunction

  function automatic logic is_bit_op(input logic [CMI_INSTR_W-1:0] code, input logic [CMI_INSTR_W-1:0] op);
    is_bit_op = ((code & CMI_OP_BIT_MASK) == op);
  endfunction

  // One kind per instruction of this group; everything else only advances the counter and drops the arm
  typedef enum logic [3:0] {
    CMI_K_OTHER,
    CMI_K_POWER_OFF_ENTRY,
    CMI_K_POWER_OFF_ARM,
    CMI_K_ROTATE_ACC_RIGHT,
    CMI_K_CLEAR_MEMORY_BIT,
    CMI_K_CLEAR_BANK_FLAG,
    CMI_K_CLEAR_CARRY,
    CMI_K_CLEAR_PORT_D,
    CMI_K_SUBROUTINE_RETURN
  } cmi_kind_t;

  function automatic cmi_kind_t decode_kind(input logic [CMI_INSTR_W-1:0] code);
    cmi_kind_t kind;
    kind = CMI_K_OTHER;
    if (is_op(code, CMI_OP_POWER_OFF_ENTRY)) begin
      kind = CMI_K_POWER_OFF_ENTRY;
    end else if (is_op(code, CMI_OP_POWER_OFF_ARM)) begin
      kind = CMI_K_POWER_OFF_ARM;
    end else if (is_op(code, CMI_OP_ROTATE_ACC_RIGHT)) begin
      kind = CMI_K_ROTATE_ACC_RIGHT;
    end else if (is_bit_op(code, CMI_OP_CLEAR_MEMORY_BIT)) begin
      kind = CMI_K_CLEAR_MEMORY_BIT;
    end else if (is_op(code, CMI_OP_CLEAR_BANK_FLAG)) begin
      kind = CMI_K_CLEAR_BANK_FLAG;
    end else if (is_op(code, CMI_OP_CLEAR_CARRY)) begin
      kind = CMI_K_CLEAR_CARRY;
    end else if (is_op(code, CMI_OP_CLEAR_PORT_D)) begin
      kind = CMI_K_CLEAR_PORT_D;
    end else if (is_op(code, CMI_OP_SUBROUTINE_RETURN)) begin
      kind = CMI_K_SUBROUTINE_RETURN;
    end
    decode_kind = kind;
  endfunction

  // Old carry enters the top, old bit 0 leaves as the new carry (carry is the top result bit)
  function automatic logic [CMI_NIB_W:0] rotate_right(input logic [CMI_NIB_W-1:0] nib, input logic carry);
    rotate_right = {nib[0], carry, nib[CMI_NIB_W-1:1]};
  endfunction

  // Read-modify-write of one nibble: only bit pos drops, the others pass unchanged
  function automatic logic [CMI_NIB_W-1:0] clear_bit(input logic [CMI_NIB_W-1:0] nib, input logic [1:0] pos);
    clear_bit = nib & ~(4'h1 << pos);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  cmi_state_t state;
  cmi_state_t next_state;
  cmi_kind_t op_kind;
  logic take;
  logic acc_load_ok;
  logic bank_set_ok;
  logic push_ok;

  always_comb begin
    next_state = state;
    next_state.mem_wr.we = 1'b0;
    op_kind = decode_kind(i_instr.code);
    // Once in backup no instruction executes until reset wakes the core
    take = i_instr.valid && state.ready && !state.backup;
    // Side inputs from the rest of the core; instruction effects win
    acc_load_ok = i_acc_load_valid && !(take && op_kind == CMI_K_ROTATE_ACC_RIGHT);
    bank_set_ok = i_bank_set && !(take && op_kind == CMI_K_CLEAR_BANK_FLAG);
    // A push shares the stack with a return, so it only lands in a free run cycle
    push_ok = i_call_valid && !take && state.ready && !state.backup;
    unique case (state.phase)
      CMI_RUN: begin
        if (take) begin
          next_state.program_counter = state.program_counter + 14'h0001;
          // Arm lasts exactly one instruction; any other opcode drops it
          next_state.power_off_arm = (op_kind == CMI_K_POWER_OFF_ARM);
          unique case (op_kind)
            CMI_K_POWER_OFF_ENTRY: begin
              if (state.power_off_arm) begin
                next_state.backup = 1'b1;
                next_state.ready = 1'b0;
              end
              // Otherwise only the counter advances
            end
            CMI_K_ROTATE_ACC_RIGHT: begin
              {next_state.carry_flag, next_state.acc} = rotate_right(state.acc, state.carry_flag);
            end
            CMI_K_CLEAR_MEMORY_BIT: begin
              next_state.mem_wr.we = 1'b1;
              next_state.mem_wr.wdata = clear_bit(i_mem_rdata, i_instr.code[1:0]);
            end
            CMI_K_CLEAR_BANK_FLAG: begin
              // Small-ROM variant leaves the bank flag as it is, but a bank set in the same cycle is still dropped
              if (i_large_rom) begin
                next_state.bank_flag = 1'b0;
              end
            end
            CMI_K_CLEAR_CARRY: begin
              next_state.carry_flag = 1'b0;
            end
            CMI_K_CLEAR_PORT_D: begin
              // Y beyond the last pin leaves the port untouched
              if (i_reg_y <= CMI_PORTD_MAX_Y) begin
                next_state.port_d[i_reg_y[2:0]] = 1'b0;
              end
            end
            CMI_K_SUBROUTINE_RETURN: begin
              next_state.phase = CMI_RETURN;
              next_state.ready = 1'b0;
            end
            CMI_K_POWER_OFF_ARM, CMI_K_OTHER: begin
              // Only the counter and the arm change
            end
          endcase
        end
        if (acc_load_ok) begin
          next_state.acc = i_acc_load;
        end
        if (bank_set_ok) begin
          next_state.bank_flag = 1'b1;
        end
        if (push_ok) begin
          next_state.stack_pointer = state.stack_pointer + 3'h1;
          next_state.return_stack[state.stack_pointer + 3'h1] = i_call_addr;
          next_state.program_counter = state.program_counter;
        end
      end
      CMI_RETURN: begin
        // Second cycle of the return; the counter step of the first cycle is overwritten
        next_state.program_counter = state.return_stack[state.stack_pointer];
        next_state.stack_pointer = state.stack_pointer - 3'h1;
        next_state.phase = CMI_RUN;
        next_state.ready = 1'b1;
      end
    endcase
  end

  // The stack is cleared too, so a return without a call lands at address zero
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state.phase <= CMI_RUN;
      state.acc <= CMI_RST_ACC;
      state.carry_flag <= CMI_RST_CARRY;
      state.bank_flag <= CMI_RST_BANK;
      state.power_off_arm <= 1'b0;
      state.backup <= 1'b0;
      state.port_d <= CMI_RST_PORTD;
      state.program_counter <= CMI_RST_PC;
      state.stack_pointer <= CMI_RST_SP;
      state.return_stack <= {CMI_STACK_DEPTH{CMI_RST_STACK_ENTRY}};
      state.mem_wr.we <= 1'b0;
      state.mem_wr.wdata <= CMI_RST_NIB;
      state.ready <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register

  assign o_ready = state.ready;
  assign o_acc = state.acc;
  assign o_carry_flag = state.carry_flag;
  assign o_bank_flag = state.bank_flag;
  assign o_backup = state.backup;
  assign o_port_d = state.port_d;
  assign o_program_counter = state.program_counter;
  assign o_stack_pointer = state.stack_pointer;
  assign o_mem_wr = state.mem_wr;

endmodule

`default_nettype wire

// File: cmi_core_props.sv
// Checker for the misc instruction group ports
`timescale 1ns/1ps
`default_nettype none
module cmi_core_props
  import cmi_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire cmi_instr_t i_instr,
  input wire logic [CMI_NIB_W-1:0] i_mem_rdata,
  input wire logic [CMI_Y_W-1:0] i_reg_y,
  input wire logic i_large_rom,
  input wire logic o_ready,
  input wire logic [CMI_NIB_W-1:0] o_acc,
  input wire logic o_carry_flag,
  input wire logic o_bank_flag,
  input wire logic o_backup,
  input wire logic [CMI_PORTD_W-1:0] o_port_d,
  input wire logic [CMI_PC_W-1:0] o_program_counter,
  input wire logic [CMI_SP_W-1:0] o_stack_pointer,
  input wire cmi_mem_wr_t o_mem_wr
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic tk = i_instr.valid && o_ready && !o_backup;
  wire logic [CMI_INSTR_W-1:0] c = i_instr.code;
  logic arm;
  // Idle cycles keep the arm, any taken instruction replaces it
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) arm <= 1'b0;
    else if (tk) arm <= c == CMI_OP_POWER_OFF_ARM;
  end
  property p_pof; tk && c == CMI_OP_POWER_OFF_ENTRY && arm |=> o_backup && !o_ready; endproperty
  a_pof: assert property (p_pof) else $error("armed power-off missed");
  property p_nop; tk && c == CMI_OP_POWER_OFF_ENTRY && !arm |=> !o_backup && o_ready; endproperty
  a_nop: assert property (p_nop) else $error("unarmed power-off acted");
  property p_rot; tk && c == CMI_OP_ROTATE_ACC_RIGHT |=>
    o_acc == {$past(o_carry_flag), $past(o_acc[3:1])} && o_carry_flag == $past(o_acc[0]); endproperty
  a_rot: assert property (p_rot) else $error("rotate wrong");
  property p_rb; tk && c[9:2] == CMI_OP_CLEAR_MEMORY_BIT[9:2] |=>
    o_mem_wr.we && o_mem_wr.wdata == ($past(i_mem_rdata) & ~(4'h1 << $past(c[1:0]))); endproperty
  a_rb: assert property (p_rb) else $error("bit clear wrong");
  property p_bank; tk && c == CMI_OP_CLEAR_BANK_FLAG && i_large_rom |=> !o_bank_flag; endproperty
  a_bank: assert property (p_bank) else $error("bank flag kept");
  property p_pd; tk && c == CMI_OP_CLEAR_PORT_D && i_reg_y <= CMI_PORTD_MAX_Y |=>
    !o_port_d[$past(i_reg_y)]; endproperty
  a_pd: assert property (p_pd) else $error("port bit kept");
  property p_rt; tk && c == CMI_OP_SUBROUTINE_RETURN |=>
    !o_ready ##1 o_ready && o_stack_pointer == $past(o_stack_pointer, 2) - 3'h1; endproperty
  a_rt: assert property (p_rt) else $error("return timing wrong");
  property p_rc; tk && c == CMI_OP_CLEAR_CARRY |=>
    !o_carry_flag && o_program_counter == $past(o_program_counter) + 14'h1; endproperty
  a_rc: assert property (p_rc) else $error("carry clear wrong");
endmodule
bind cmi_core cmi_core_props u_props (.*);
`default_nettype wire

// File: cmi_core_tb_top.sv
// Self-checking bench for the misc instruction group
`timescale 1ns/1ps
`default_nettype none
module cmi_core_tb_top;
  import cmi_pkg::*;
  logic i_ref_clk = 0, i_rst_n = 0, i_large_rom = 0, i_call_valid = 0, i_acc_load_valid = 0, i_bank_set = 0;
  cmi_instr_t i_instr = '0;
  logic [3:0] i_mem_rdata = 0, i_reg_y = 0, i_acc_load = 0, o_acc;
  logic [13:0] i_call_addr = 0, o_program_counter;
  logic o_ready, o_carry_flag, o_bank_flag, o_backup;
  logic [4:0] o_port_d;
  logic [2:0] o_stack_pointer;
  cmi_mem_wr_t o_mem_wr;
  int error_cnt = 0, checks = 0, acc = 0, cy = 0, bk = 0, pd = 31, pc = 0;
  int sp = 0, arm = 0, off = 0, mid = 0, we = 0, wd = 0;
  int stk [8] = '{default: 0};
  cmi_core u_dut (.*);
  initial forever #2.5 i_ref_clk = ~i_ref_clk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp;
    logic [34:0] g, e;
    g = {o_ready, o_backup, o_acc, o_carry_flag, o_bank_flag, o_port_d, o_program_counter, o_stack_pointer, o_mem_wr};
    e = {1'(!off && !mid), 1'(off), 4'(acc), 1'(cy), 1'(bk), 5'(pd), 14'(pc), 3'(sp), 1'(we), 4'(wd)};
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One instruction slot; a return also spends its second cycle here
  task automatic ex(input logic [9:0] c, input logic v);
    logic tk;
    tk = v && !off;
    i_instr = '{v, c};
    i_mem_rdata = $urandom;
    i_reg_y = $urandom % 8;
    we = 0;
    if (i_bank_set) bk = 1;
    if (i_call_valid && !tk && !off) begin
      sp = (sp + 1) % 8;
      stk[sp] = i_call_addr;
    end
    if (i_acc_load_valid) acc = i_acc_load;
    if (tk) begin
      pc = (pc + 1) % 16384;
      if (c == CMI_OP_ROTATE_ACC_RIGHT) begin
        acc = cy * 8 + acc / 2 + 16 * (acc % 2);
        cy = acc / 16;
        acc = acc % 16;
      end
      if (c == CMI_OP_CLEAR_CARRY) cy = 0;
      if (c == CMI_OP_CLEAR_BANK_FLAG && i_large_rom) bk = 0;
      if (c == CMI_OP_CLEAR_PORT_D && i_reg_y <= 4) pd &= ~(1 << i_reg_y);
      if (c[9:2] == CMI_OP_CLEAR_MEMORY_BIT[9:2]) begin
        we = 1;
        wd = i_mem_rdata & ~(1 << c[1:0]);
      end
      if (c == CMI_OP_POWER_OFF_ENTRY && arm) off = 1;
      arm = c == CMI_OP_POWER_OFF_ARM;
      mid = c == CMI_OP_SUBROUTINE_RETURN;
    end
    @(negedge i_ref_clk);
    cmp();
    if (mid) begin
      i_instr.valid = 0;
      we = 0;
      mid = 0;
      pc = stk[sp];
      sp = (sp + 7) % 8;
      @(negedge i_ref_clk);
      cmp();
    end
  endtask
  initial begin
    void'($urandom(32'h10DE));
    repeat (3) @(negedge i_ref_clk);
    i_rst_n = 1;
    i_call_valid = 1;
    repeat (2) begin
      i_call_addr = $urandom;
      ex(0, 0);
    end
    i_call_valid = 0;
    {i_acc_load_valid, i_bank_set, i_acc_load} = {2'h3, 4'($urandom | 1)};
    ex(0, 0);
    {i_acc_load_valid, i_bank_set} = 2'h0;
    repeat (6) ex(CMI_OP_ROTATE_ACC_RIGHT, 1);
    ex(CMI_OP_CLEAR_CARRY, 1);
    for (int j = 0; j < 4; j++) ex(CMI_OP_CLEAR_MEMORY_BIT + j, 1);
    ex(CMI_OP_CLEAR_BANK_FLAG, 1);
    i_large_rom = 1;
    ex(CMI_OP_CLEAR_BANK_FLAG, 1);
    repeat (8) ex(CMI_OP_CLEAR_PORT_D, 1);
    repeat (2) ex(CMI_OP_SUBROUTINE_RETURN, 1);
    $display("data tests done");
    ex(CMI_OP_POWER_OFF_ARM, 1);
    ex(CMI_OP_ROTATE_ACC_RIGHT, 1);
    ex(CMI_OP_POWER_OFF_ENTRY, 1);
    ex(CMI_OP_POWER_OFF_ARM, 1);
    ex(0, 0);
    ex(CMI_OP_POWER_OFF_ENTRY, 1);
    ex(CMI_OP_CLEAR_CARRY, 1);
    ex(CMI_OP_SUBROUTINE_RETURN, 1);
    $display("power-off tests done");
    // Only reset leaves the back-up state
    i_rst_n = 0;
    @(negedge i_ref_clk);
    i_rst_n = 1;
    acc = 0;
    cy = 0;
    bk = 0;
    pd = 31;
    pc = 0;
    sp = 0;
    arm = 0;
    off = 0;
    wd = 0;
    stk = '{default: 0};
    ex(CMI_OP_ROTATE_ACC_RIGHT, 1);
    $display("reset test done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: cmi_pkg.sv
// Package with opcodes, widths, reset values and carriers of the misc instruction group
package cmi_pkg;

  localparam int CMI_INSTR_W = 10;
  localparam int CMI_NIB_W = 4;
  localparam int CMI_PC_W = 14;
  localparam int CMI_SP_W = 3;
  localparam int CMI_STACK_DEPTH = 8;
  localparam int CMI_PORTD_W = 5;
  localparam int CMI_Y_W = 4;

  // Opcodes
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_POWER_OFF_ENTRY = 10'h002;
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_POWER_OFF_ARM = 10'h05B;
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_ROTATE_ACC_RIGHT = 10'h01D;
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_CLEAR_MEMORY_BIT = 10'h04C;
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_CLEAR_BANK_FLAG = 10'h040;
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_CLEAR_CARRY = 10'h006;
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_CLEAR_PORT_D = 10'h014;
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_SUBROUTINE_RETURN = 10'h044;
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_BIT_MASK = 10'h3FC;
  localparam logic [CMI_INSTR_W-1:0] CMI_OP_BIT_POS = 10'h000;

  // Highest valid port D index held in Y
  localparam logic [CMI_Y_W-1:0] CMI_PORTD_MAX_Y = 4'h4;

  // Reset values
  localparam logic [CMI_NIB_W-1:0] CMI_RST_ACC = 4'h0;
  localparam logic CMI_RST_CARRY = 1'b0;
  localparam logic CMI_RST_BANK = 1'b0;
  localparam logic [CMI_PORTD_W-1:0] CMI_RST_PORTD = 5'h1F;
  localparam logic [CMI_PC_W-1:0] CMI_RST_PC = 14'h0000;
  localparam logic [CMI_SP_W-1:0] CMI_RST_SP = 3'h0;
  localparam logic [CMI_PC_W-1:0] CMI_RST_STACK_ENTRY = 14'h0000;
  localparam logic [CMI_NIB_W-1:0] CMI_RST_NIB = 4'h0;

  typedef enum logic [0:0] {CMI_RUN, CMI_RETURN} cmi_phase_t;

  // Instruction carrier from fetch
  typedef struct packed {
    logic valid;
    logic [CMI_INSTR_W-1:0] code;
  } cmi_instr_t;

  // Memory write carrier to data RAM
  typedef struct packed {
    logic we;
    logic [CMI_NIB_W-1:0] wdata;
  } cmi_mem_wr_t;

  typedef struct packed {
    cmi_phase_t phase;
    logic [CMI_NIB_W-1:0] acc;
    logic carry_flag;
    logic bank_flag;
    logic power_off_arm;
    logic backup;
    logic [CMI_PORTD_W-1:0] port_d;
    logic [CMI_PC_W-1:0] program_counter;
    logic [CMI_SP_W-1:0] stack_pointer;
    logic [CMI_STACK_DEPTH-1:0][CMI_PC_W-1:0] return_stack;
    cmi_mem_wr_t mem_wr;
    logic ready;
  } cmi_state_t;

endpackage
